// ### pkg/pia_cfg.svh
// constants for the application interrupt and ecc flag sideband
`ifndef PIA_CFG_SVH
`define PIA_CFG_SVH

`define PIA_TC_W          3
`define PIA_VEC_W         5
`define PIA_ADDR_W        64
`define PIA_DATA_W        16
`define PIA_MME_W         3
`define PIA_ECC_W         32
`define PIA_POS_W         5
`define PIA_PHASES        2
`define PIA_MSG_ASSERT_A  16'h0020
`define PIA_MSG_DEASSERT_A 16'h0024
`define PIA_INTX_TC       3'h0
`define PIA_MME_MAX       3'h5

`endif

// ### pkg/pia_pkg.sv
// types for the application interrupt and ecc flag sideband
`default_nettype none
`include "pia_cfg.svh"

package pia_pkg;

    typedef enum logic [1:0] {
        PIA_KIND_NONE     = 2'h0,
        PIA_KIND_MSI      = 2'h1,
        PIA_KIND_ASSERT   = 2'h2,
        PIA_KIND_DEASSERT = 2'h3
    } pia_kind_e;

    typedef enum logic [5:0] {
        PIA_ST_IDLE     = 6'h01,
        PIA_ST_MSI_SEND = 6'h02,
        PIA_ST_MSI_ACK  = 6'h04,
        PIA_ST_INT_SEND = 6'h08,
        PIA_ST_INT_ACK  = 6'h10,
        PIA_ST_MSI_HOLD = 6'h20
    } pia_state_e;

    // outgoing message request toward the transmit path
    typedef struct packed {
        pia_kind_e                 kind;
        logic [`PIA_TC_W-1:0]      tc;
        logic [`PIA_ADDR_W-1:0]    addr;
        logic [`PIA_DATA_W-1:0]    data;
    } pia_msg_s;

    // msi capability settings held by configuration space
    typedef struct packed {
        logic                      enable;
        logic [`PIA_MME_W-1:0]     mme;
        logic [`PIA_ADDR_W-1:0]    addr;
        logic [`PIA_DATA_W-1:0]    data;
    } pia_msi_cap_s;

    // one word leaving an ecc decoder, split into fast phases
    typedef struct packed {
        logic [`PIA_PHASES-1:0]    valid;
        logic [`PIA_PHASES-1:0]    cor;
        logic [`PIA_PHASES-1:0]    uncor;
        logic [`PIA_ECC_W-1:0]     word;
        logic [`PIA_POS_W-1:0]     pos;
    } pia_ecc_dec_s;

endpackage
`default_nettype wire

// ### hw/pia_ecc_flag.sv
// ecc decoder flag stretcher and single bit corrector
`timescale 1ns/1ps
`default_nettype none
`include "pia_cfg.svh"

module pia_ecc_flag (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire pia_pkg::pia_ecc_dec_s   dec,
    output logic                         cor_flag,
    output logic                         uncor_flag,
    output logic [`PIA_ECC_W-1:0]        fixed_word,
    output logic                         fixed_valid
);

    logic                    cor_flag_reg;
    logic                    uncor_flag_reg;
    logic [`PIA_ECC_W-1:0]   fixed_word_reg;
    logic                    fixed_valid_reg;
    logic                    cor_next;
    logic                    uncor_next;

    ////////////////////////////////////////////////////////////////////////////
    // both fast phases fold into one slow cycle; a report in either phase
    // becomes exactly one slow pulse, two in one cycle merge into one
    assign cor_next   = |(dec.valid & dec.cor);
    assign uncor_next = |(dec.valid & dec.uncor);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cor_flag_reg   <= 1'b0;
            uncor_flag_reg <= 1'b0;
        end else begin
            cor_flag_reg   <= cor_next;
            uncor_flag_reg <= uncor_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // correctable word is repaired here, so no caller ever sees the bad bit
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fixed_word_reg  <= '0;
            fixed_valid_reg <= 1'b0;
        end else begin
            fixed_valid_reg <= |dec.valid;
            if (cor_next) begin
                fixed_word_reg <= dec.word ^ (`PIA_ECC_W'(1) << dec.pos);
            end else begin
                fixed_word_reg <= dec.word;
            end
        end
    end

    assign cor_flag    = cor_flag_reg;
    assign uncor_flag  = uncor_flag_reg;
    assign fixed_word  = fixed_word_reg;
    assign fixed_valid = fixed_valid_reg;

endmodule
`default_nettype wire

// ### hw/pia_top.sv
// application interrupt requests and ecc debug flags of the endpoint core
// Operation
// - ecc flags pulse one cycle, core clock
// - erroneous decoder data raises matching flag, except rx uncorrectable (no rx uncorrected output)
// - correctable errors repaired internally, no loss
// - rx corrected flag: fast pulse stretched
// - separate retry buffer uncorrectable flag
// - retry buffer corrected error flag
// - msi request sends msi memory write
// - acknowledge accepted msi request
// - msi uses supplied three bit class
// - vector fills enabled low data bits
// - level rise sends assert message
// - level fall sends deassert message
// - ack after assert message sent
// - ack after deassert message sent
`timescale 1ns/1ps
`default_nettype none
`include "pia_cfg.svh"

module pia_top (
    input  wire logic                    CLK,
    input  wire logic                    RST_N,
    input  wire logic                    MSG_IRQ_REQ,
    input  wire logic [`PIA_TC_W-1:0]    MSG_IRQ_TRAFFIC_CLASS,
    input  wire logic [`PIA_VEC_W-1:0]   MSG_IRQ_VECTOR,
    output logic                         MSG_IRQ_ACK,
    input  wire logic                    LEGACY_IRQ_LEVEL,
    output logic                         LEGACY_IRQ_ACK,
    input  wire pia_pkg::pia_msi_cap_s   MSI_CAP,
    output pia_pkg::pia_msg_s            TX_MSG,
    output logic                         TX_MSG_VALID,
    input  wire logic                    TX_MSG_READY,
    input  wire logic                    TX_MSG_SENT,
    input  wire pia_pkg::pia_ecc_dec_s   RX_ECC_DEC,
    input  wire pia_pkg::pia_ecc_dec_s   RETRY_ECC_DEC,
    output logic                         RX_BUF_CORRECTED_FLAG,
    output logic                         RETRY_BUF_CORRECTED_FLAG,
    output logic                         RETRY_BUF_UNCORRECTED_FLAG,
    output logic [`PIA_ECC_W-1:0]        RX_BUF_WORD,
    output logic                         RX_BUF_WORD_VALID,
    output logic [`PIA_ECC_W-1:0]        RETRY_BUF_WORD,
    output logic                         RETRY_BUF_WORD_VALID
);

    pia_pkg::pia_state_e     state_reg;
    pia_pkg::pia_msg_s       msg_reg;
    logic                    valid_reg;
    logic                    msi_ack_reg;
    logic                    int_ack_reg;
    logic                    int_sent_level_reg;
    logic                    msi_armed_reg;
    logic                    int_change;
    logic                    msi_start;

    ////////////////////////////////////////////////////////////////////////////
    // msi data: low bits from the vector only where multiple message enable
    // opens them; mme above five is clamped, the vector is only five bits
    function automatic logic [`PIA_DATA_W-1:0] msi_data(
        input logic [`PIA_DATA_W-1:0] base,
        input logic [`PIA_MME_W-1:0]  mme,
        input logic [`PIA_VEC_W-1:0]  vec
    );
        logic [`PIA_DATA_W-1:0] mask;
        logic [`PIA_MME_W-1:0]  width;
        width = (mme > `PIA_MME_MAX) ? `PIA_MME_MAX : mme;
        mask  = `PIA_DATA_W'((17'h00001 << width) - 17'h00001);
        msi_data = (base & ~mask) | ({{(`PIA_DATA_W-`PIA_VEC_W){1'b0}}, vec} & mask);
    endfunction

    function automatic pia_pkg::pia_msg_s intx_msg(input logic level);
        pia_pkg::pia_msg_s m;
        m.kind = level ? pia_pkg::PIA_KIND_ASSERT : pia_pkg::PIA_KIND_DEASSERT;
        m.tc   = `PIA_INTX_TC;
        m.addr = '0;
        m.data = level ? `PIA_MSG_ASSERT_A : `PIA_MSG_DEASSERT_A;
        intx_msg = m;
    endfunction

    // level already on the wire wins over a pending msi, so intx order holds
    assign int_change = (LEGACY_IRQ_LEVEL != int_sent_level_reg);
    // a request still held after its ack is not taken twice
    assign msi_start  = MSG_IRQ_REQ && msi_armed_reg && MSI_CAP.enable;

    ////////////////////////////////////////////////////////////////////////////
    // message sequencer
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state_reg <= pia_pkg::PIA_ST_IDLE;
        end else begin
            case (state_reg)
                pia_pkg::PIA_ST_IDLE: begin
                    if (int_change) begin
                        state_reg <= pia_pkg::PIA_ST_INT_SEND;
                    end else if (msi_start) begin
                        state_reg <= pia_pkg::PIA_ST_MSI_SEND;
                    end
                end
                pia_pkg::PIA_ST_MSI_SEND: begin
                    if (TX_MSG_READY) begin
                        state_reg <= pia_pkg::PIA_ST_MSI_ACK;
                    end
                end
                pia_pkg::PIA_ST_MSI_ACK: begin
                    state_reg <= pia_pkg::PIA_ST_MSI_HOLD;
                end
                pia_pkg::PIA_ST_MSI_HOLD: begin
                    state_reg <= pia_pkg::PIA_ST_IDLE;
                end
                pia_pkg::PIA_ST_INT_SEND: begin
                    if (TX_MSG_READY) begin
                        state_reg <= pia_pkg::PIA_ST_INT_ACK;
                    end
                end
                pia_pkg::PIA_ST_INT_ACK: begin
                    if (TX_MSG_SENT) begin
                        state_reg <= pia_pkg::PIA_ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= pia_pkg::PIA_ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // message contents, captured once at start and held while valid
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            msg_reg <= '0;
        end else if (state_reg == pia_pkg::PIA_ST_IDLE) begin
            if (int_change) begin
                msg_reg <= intx_msg(LEGACY_IRQ_LEVEL);
            end else if (msi_start) begin
                msg_reg.kind <= pia_pkg::PIA_KIND_MSI;
                msg_reg.tc   <= MSG_IRQ_TRAFFIC_CLASS;
                msg_reg.addr <= MSI_CAP.addr;
                msg_reg.data <= msi_data(MSI_CAP.data, MSI_CAP.mme, MSG_IRQ_VECTOR);
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            valid_reg <= 1'b0;
        end else if (state_reg == pia_pkg::PIA_ST_IDLE) begin
            valid_reg <= int_change || msi_start;
        end else if (TX_MSG_READY) begin
            valid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // level last queued for upstream; set when each intx message starts from idle, before acceptance
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            int_sent_level_reg <= 1'b0;
        end else begin
            if (state_reg == pia_pkg::PIA_ST_IDLE && int_change) begin
                int_sent_level_reg <= LEGACY_IRQ_LEVEL;
            end
        end
    end

    // ack one cycle once the intx message has left the transmit path
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            int_ack_reg <= 1'b0;
        end else begin
            int_ack_reg <= (state_reg == pia_pkg::PIA_ST_INT_ACK) && TX_MSG_SENT;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // msi handshake: ack once per accepted request, rearm on request low
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            msi_ack_reg   <= 1'b0;
            msi_armed_reg <= 1'b1;
        end else begin
            msi_ack_reg <= (state_reg == pia_pkg::PIA_ST_MSI_SEND) && TX_MSG_READY;
            if (state_reg == pia_pkg::PIA_ST_IDLE && msi_start && !int_change) begin
                msi_armed_reg <= 1'b0;
            end else if (!MSG_IRQ_REQ) begin
                msi_armed_reg <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // ecc flags; purely observational, nothing here reacts to them
    // rx flag is garbage until the rx buffer first fills
    // after an uncorrectable report the application resets the core
    pia_ecc_flag u_rx_ecc (
        .clk         (CLK),
        .rst_n       (RST_N),
        .dec         (RX_ECC_DEC),
        .cor_flag    (RX_BUF_CORRECTED_FLAG),
        .uncor_flag  (),
        .fixed_word  (RX_BUF_WORD),
        .fixed_valid (RX_BUF_WORD_VALID)
    );

    pia_ecc_flag u_retry_ecc (
        .clk         (CLK),
        .rst_n       (RST_N),
        .dec         (RETRY_ECC_DEC),
        .cor_flag    (RETRY_BUF_CORRECTED_FLAG),
        .uncor_flag  (RETRY_BUF_UNCORRECTED_FLAG),
        .fixed_word  (RETRY_BUF_WORD),
        .fixed_valid (RETRY_BUF_WORD_VALID)
    );

    assign TX_MSG         = msg_reg;
    assign TX_MSG_VALID   = valid_reg;
    assign MSG_IRQ_ACK    = msi_ack_reg;
    assign LEGACY_IRQ_ACK = int_ack_reg;

endmodule
`default_nettype wire

// ### tb/pia_top_monitor.sv
// concurrent checks on the interrupt and ecc flag sideband ports
`timescale 1ns/1ps
`default_nettype none
`include "pia_cfg.svh"

module pia_top_monitor (
    input wire logic                  CLK,
    input wire logic                  RST_N,
    input wire logic [`PIA_TC_W-1:0]  MSG_IRQ_TRAFFIC_CLASS,
    input wire logic                  MSG_IRQ_ACK,
    input wire logic                  LEGACY_IRQ_ACK,
    input wire pia_pkg::pia_msi_cap_s MSI_CAP,
    input wire pia_pkg::pia_msg_s     TX_MSG,
    input wire logic                  TX_MSG_VALID,
    input wire logic                  TX_MSG_READY,
    input wire logic                  TX_MSG_SENT,
    input wire pia_pkg::pia_ecc_dec_s RX_ECC_DEC,
    input wire pia_pkg::pia_ecc_dec_s RETRY_ECC_DEC,
    input wire logic                  RX_BUF_CORRECTED_FLAG,
    input wire logic                  RETRY_BUF_CORRECTED_FLAG,
    input wire logic                  RETRY_BUF_UNCORRECTED_FLAG,
    input wire logic [`PIA_ECC_W-1:0] RX_BUF_WORD
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    ////////////////////////////////////////
    a_msi_ack_cause: assert property (MSG_IRQ_ACK |-> $past(TX_MSG_VALID && TX_MSG_READY && TX_MSG.kind == pia_pkg::PIA_KIND_MSI))
        else $error("msi ack without accepted msi");
    a_msi_ack_pulse: assert property (MSG_IRQ_ACK |=> !MSG_IRQ_ACK)
        else $error("msi ack longer than one cycle");
    a_msi_fields: assert property (TX_MSG_VALID && TX_MSG.kind == pia_pkg::PIA_KIND_MSI |-> TX_MSG.tc == MSG_IRQ_TRAFFIC_CLASS && TX_MSG.addr == MSI_CAP.addr)
        else $error("msi class or address wrong");
    a_intx_fields: assert property (TX_MSG_VALID && TX_MSG.kind[1] |-> TX_MSG.tc == 3'h0 && TX_MSG.data == (TX_MSG.kind[0] ? `PIA_MSG_DEASSERT_A : `PIA_MSG_ASSERT_A))
        else $error("intx message fields wrong");
    a_valid_hold: assert property (TX_MSG_VALID && !TX_MSG_READY |=> TX_MSG_VALID && $stable(TX_MSG))
        else $error("message dropped before taken");
    a_legacy_ack_sent: assert property (LEGACY_IRQ_ACK |-> $past(TX_MSG_SENT) ##1 !LEGACY_IRQ_ACK)
        else $error("legacy ack not after send");
    // first edge after reset still sees decoder input from inside reset
    a_rx_cor_flag: assert property ($past(RST_N) |-> RX_BUF_CORRECTED_FLAG == $past(|(RX_ECC_DEC.valid & RX_ECC_DEC.cor)))
        else $error("rx corrected flag wrong");
    a_retry_cor_flag: assert property ($past(RST_N) |-> RETRY_BUF_CORRECTED_FLAG == $past(|(RETRY_ECC_DEC.valid & RETRY_ECC_DEC.cor)))
        else $error("retry corrected flag wrong");
    a_retry_uncor_flag: assert property ($past(RST_N) |-> RETRY_BUF_UNCORRECTED_FLAG == $past(|(RETRY_ECC_DEC.valid & RETRY_ECC_DEC.uncor)))
        else $error("retry uncorrected flag wrong");
    a_rx_word_fix: assert property ($past(RST_N) && $past(|(RX_ECC_DEC.valid & RX_ECC_DEC.cor)) |-> RX_BUF_WORD == $past(RX_ECC_DEC.word ^ (32'h1 << RX_ECC_DEC.pos)))
        else $error("rx word not corrected");
endmodule

bind pia_top pia_top_monitor u_mon (.CLK(CLK), .RST_N(RST_N), .MSG_IRQ_TRAFFIC_CLASS(MSG_IRQ_TRAFFIC_CLASS),
    .MSG_IRQ_ACK(MSG_IRQ_ACK), .LEGACY_IRQ_ACK(LEGACY_IRQ_ACK), .MSI_CAP(MSI_CAP), .TX_MSG(TX_MSG),
    .TX_MSG_VALID(TX_MSG_VALID), .TX_MSG_READY(TX_MSG_READY), .TX_MSG_SENT(TX_MSG_SENT), .RX_ECC_DEC(RX_ECC_DEC),
    .RETRY_ECC_DEC(RETRY_ECC_DEC), .RX_BUF_CORRECTED_FLAG(RX_BUF_CORRECTED_FLAG),
    .RETRY_BUF_CORRECTED_FLAG(RETRY_BUF_CORRECTED_FLAG), .RETRY_BUF_UNCORRECTED_FLAG(RETRY_BUF_UNCORRECTED_FLAG),
    .RX_BUF_WORD(RX_BUF_WORD));
`default_nettype wire

// ### tb/pia_tx_sink.sv
// transmit path model: takes messages after a lag, reports intx sends
`timescale 1ns/1ps
`default_nettype none

module pia_tx_sink (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire pia_pkg::pia_msg_s msg,
    input  wire logic              msg_valid,
    input  wire logic [3:0]        lag,
    output logic                   msg_ready,
    output logic                   msg_sent
);
    logic [3:0] wait_reg;
    logic [3:0] sent_reg;
    ////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (!rst_n || (msg_valid && msg_ready)) begin
            msg_ready <= 1'b0;
            wait_reg  <= 4'h0;
        end else if (msg_valid) begin
            msg_ready <= (wait_reg >= lag);
            wait_reg  <= wait_reg + 4'h1;
        end
    end
    // send trails acceptance so ack timing is not tied to ready
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sent_reg <= 4'h0;
            msg_sent <= 1'b0;
        end else begin
            msg_sent <= (sent_reg == 4'h1);
            if (msg_valid && msg_ready && msg.kind != pia_pkg::PIA_KIND_MSI) sent_reg <= lag + 4'h2;
            else if (sent_reg != 4'h0) sent_reg <= sent_reg - 4'h1;
        end
    end
endmodule
`default_nettype wire

// ### tb/test_pcie_app_irq_and_ecc_flags.sv
// self-checking bench for the interrupt and ecc flag sideband
`timescale 1ns/1ps
`default_nettype none
`include "pia_cfg.svh"

module test_pcie_app_irq_and_ecc_flags;
    logic                  CLK, RST_N, MSG_IRQ_REQ, LEGACY_IRQ_LEVEL, MSG_IRQ_ACK, LEGACY_IRQ_ACK;
    logic                  TX_MSG_VALID, TX_MSG_READY, TX_MSG_SENT, RX_BUF_CORRECTED_FLAG;
    logic                  RETRY_BUF_CORRECTED_FLAG, RETRY_BUF_UNCORRECTED_FLAG;
    logic                  RX_BUF_WORD_VALID, RETRY_BUF_WORD_VALID;
    logic [`PIA_TC_W-1:0]  MSG_IRQ_TRAFFIC_CLASS;
    logic [`PIA_VEC_W-1:0] MSG_IRQ_VECTOR;
    logic [`PIA_ECC_W-1:0] RX_BUF_WORD, RETRY_BUF_WORD;
    logic [3:0]            lag;
    logic [68:0]           e;
    pia_pkg::pia_msi_cap_s MSI_CAP;
    pia_pkg::pia_msg_s     TX_MSG;
    pia_pkg::pia_ecc_dec_s RX_ECC_DEC, RETRY_ECC_DEC;
    pia_pkg::pia_msg_s     msg_q[$];
    logic [68:0]           ecc_q[$];
    int                    num_errors = 0;
    int                    num_checks = 0;

    pia_top dut (.CLK(CLK), .RST_N(RST_N), .MSG_IRQ_REQ(MSG_IRQ_REQ), .MSG_IRQ_TRAFFIC_CLASS(MSG_IRQ_TRAFFIC_CLASS),
        .MSG_IRQ_VECTOR(MSG_IRQ_VECTOR), .MSG_IRQ_ACK(MSG_IRQ_ACK), .LEGACY_IRQ_LEVEL(LEGACY_IRQ_LEVEL),
        .LEGACY_IRQ_ACK(LEGACY_IRQ_ACK), .MSI_CAP(MSI_CAP), .TX_MSG(TX_MSG), .TX_MSG_VALID(TX_MSG_VALID),
        .TX_MSG_READY(TX_MSG_READY), .TX_MSG_SENT(TX_MSG_SENT), .RX_ECC_DEC(RX_ECC_DEC), .RETRY_ECC_DEC(RETRY_ECC_DEC),
        .RX_BUF_CORRECTED_FLAG(RX_BUF_CORRECTED_FLAG), .RETRY_BUF_CORRECTED_FLAG(RETRY_BUF_CORRECTED_FLAG),
        .RETRY_BUF_UNCORRECTED_FLAG(RETRY_BUF_UNCORRECTED_FLAG), .RX_BUF_WORD(RX_BUF_WORD),
        .RX_BUF_WORD_VALID(RX_BUF_WORD_VALID), .RETRY_BUF_WORD(RETRY_BUF_WORD),
        .RETRY_BUF_WORD_VALID(RETRY_BUF_WORD_VALID));
    pia_tx_sink u_sink (.clk(CLK), .rst_n(RST_N), .msg(TX_MSG), .msg_valid(TX_MSG_VALID), .lag(lag),
        .msg_ready(TX_MSG_READY), .msg_sent(TX_MSG_SENT));
    ////////////////////////////////////////
    task automatic check_val(input string n, input logic [31:0] x, input logic [31:0] g);
        num_checks++;
        if (g !== x) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic check_msg(input pia_pkg::pia_msg_s x, input pia_pkg::pia_msg_s g);
        num_checks++;
        if (g !== x) begin
            num_errors++;
            $display("unexpected tx message expected %h seen %h", x, g);
        end
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic wait_ack(input bit legacy);
        int n;
        n = 0;
        while ((legacy ? LEGACY_IRQ_ACK : MSG_IRQ_ACK) !== 1'b1 && n < 100) begin
            @(negedge CLK);
            n++;
        end
        check_val(legacy ? "intx ack" : "msi ack", 32'h1, legacy ? LEGACY_IRQ_ACK : MSG_IRQ_ACK);
    endtask
    task automatic msi(input int i);
        logic [15:0] mask;
        @(negedge CLK);
        lag = 4'($urandom_range(3));
        MSI_CAP = '{enable:(i != 3), mme:3'(i), addr:{$urandom, $urandom}, data:16'($urandom)};
        MSG_IRQ_TRAFFIC_CLASS = 3'(i);
        MSG_IRQ_VECTOR = 5'($urandom);
        mask = 16'((32'h1 << ((i > 5) ? 5 : i)) - 1);
        msg_q.push_back('{kind:pia_pkg::PIA_KIND_MSI, tc:3'(i), addr:MSI_CAP.addr,
                          data:(MSI_CAP.data & ~mask) | ({11'h0, MSG_IRQ_VECTOR} & mask)});
        MSG_IRQ_REQ = 1'b1;
        repeat ((i == 3) ? 6 : 0) begin
            @(negedge CLK);
            check_val("msi while disabled", 32'h0, TX_MSG_VALID);
        end
        MSI_CAP.enable = 1'b1;
        wait_ack(1'b0);
        // request left high after its ack must not start a second message
        repeat ((i == 5) ? 4 : 0) begin
            @(negedge CLK);
            check_val("msi taken twice", 32'h0, TX_MSG_VALID);
        end
        MSG_IRQ_REQ = 1'b0;
    endtask
    task automatic intx(input logic lvl);
        @(negedge CLK);
        lag = 4'($urandom_range(3));
        msg_q.push_back('{kind:lvl ? pia_pkg::PIA_KIND_ASSERT : pia_pkg::PIA_KIND_DEASSERT, tc:3'h0, addr:64'h0,
                          data:lvl ? `PIA_MSG_ASSERT_A : `PIA_MSG_DEASSERT_A});
        LEGACY_IRQ_LEVEL = lvl;
        wait_ack(1'b1);
    endtask
    // rx flag taken as meaningful only inside this burst
    task automatic ecc_burst;
        pia_pkg::pia_ecc_dec_s rx, rt;
        for (int i = 0; i < 40; i++) begin
            @(negedge CLK);
            rx = 43'({$urandom, $urandom});
            rt = 43'({$urandom, $urandom});
            {RX_ECC_DEC, RETRY_ECC_DEC} = {rx, rt};
            ecc_q.push_back({|(rx.valid & rx.cor), |(rt.valid & rt.cor), |(rt.valid & rt.uncor), |rx.valid, |rt.valid,
                             (|(rx.valid & rx.cor)) ? rx.word ^ (32'h1 << rx.pos) : rx.word,
                             (|(rt.valid & rt.cor)) ? rt.word ^ (32'h1 << rt.pos) : rt.word});
        end
        @(negedge CLK);
        {RX_ECC_DEC, RETRY_ECC_DEC} = '0;
    endtask
    ////////////////////////////////////////
    // handshake seen at the falling edge, away from the edge that updates it
    always @(negedge CLK) begin
        if (TX_MSG_VALID === 1'b1 && TX_MSG_READY === 1'b1) begin
            if (msg_q.size() == 0) msg_q.push_back('0);
            check_msg(msg_q.pop_front(), TX_MSG);
        end
    end
    // flags only observed, never fed back into stimulus
    always @(posedge CLK) begin
        #1;
        if (ecc_q.size() > 0) begin
            e = ecc_q.pop_front();
            check_val("rx corrected flag", 32'(e[68]), RX_BUF_CORRECTED_FLAG);
            check_val("retry corrected flag", 32'(e[67]), RETRY_BUF_CORRECTED_FLAG);
            check_val("retry uncorrected flag", 32'(e[66]), RETRY_BUF_UNCORRECTED_FLAG);
            check_val("rx word valid", 32'(e[65]), RX_BUF_WORD_VALID);
            check_val("retry word valid", 32'(e[64]), RETRY_BUF_WORD_VALID);
            check_val("rx word", e[63:32], RX_BUF_WORD);
            check_val("retry word", e[31:0], RETRY_BUF_WORD);
        end
    end
    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end
    initial begin
        repeat (20000) @(posedge CLK);
        num_errors++;
        test_done();
    end
    initial begin
        void'($urandom(32'h6d505859));
        {RST_N, MSG_IRQ_REQ, LEGACY_IRQ_LEVEL, MSG_IRQ_TRAFFIC_CLASS, MSG_IRQ_VECTOR, lag} = '0;
        {MSI_CAP, RX_ECC_DEC, RETRY_ECC_DEC} = '0;
        repeat (4) @(negedge CLK);
        RST_N = 1'b1;
        for (int i = 0; i < 8; i++) msi(i);
        intx(1'b1);
        intx(1'b0);
        ecc_burst();
        // core reset after an uncorrectable report
        @(negedge CLK);
        RST_N = 1'b0;
        repeat (2) @(negedge CLK);
        RST_N = 1'b1;
        check_val("uncorrected flag after reset", 32'h0, RETRY_BUF_UNCORRECTED_FLAG);
        intx(1'b1);
        intx(1'b0);
        repeat (4) @(negedge CLK);
        check_val("messages not sent", 32'h0, msg_q.size());
        test_done();
    end
endmodule
`default_nettype wire
